// ===== hw/pdec_completion_event_pair.sv
// one instruction address compare pair: qualifiers, exact or range compare
// assumes cfg is the 16-bit pair slice and addresses are byte addresses
module pdec_completion_event_pair
	import pdec_pkg::*;
(
	input  wire logic [15:0] cfg,
	input  wire logic        reversed,
	input  wire logic [31:0] cmp_lo,
	input  wire logic [31:0] cmp_hi,
	input  wire logic [31:0] addr,
	input  wire logic        problem_state_bit,
	input  wire logic        instr_space_bit,
	output logic             hit_lo,
	output logic             hit_hi,
	output logic             range_mode
);
	logic [1:0] mode;
	logic       q_lo;
	logic       q_hi;
	logic       in_range;

	// auto-toggle reverses inclusive and exclusive, exact is untouched
	assign mode = cfg[PAIR_MODE+:2] ^ {1'b0, reversed & cfg[PAIR_MODE+1]};
	assign range_mode = mode[1];
	assign q_lo = pdec_sel_ok(cfg[PAIR_US1+:2], problem_state_bit)
		& pdec_sel_ok(cfg[PAIR_ER1+:2], instr_space_bit);
	assign q_hi = pdec_sel_ok(cfg[PAIR_US2+:2], problem_state_bit)
		& pdec_sel_ok(cfg[PAIR_ER2+:2], instr_space_bit);
	// word compare only: the two low address bits never take part
	assign in_range = (addr[31:2] >= cmp_lo[31:2]) && (addr[31:2] < cmp_hi[31:2]);

	always_comb
	begin
		hit_lo = 1'b0;
		hit_hi = 1'b0;
		case (mode)
			MODE_EXACT:
			begin
				hit_lo = q_lo && (addr[31:2] == cmp_lo[31:2]);
				hit_hi = q_hi && (addr[31:2] == cmp_hi[31:2]);
			end
			MODE_INCL: hit_lo = q_lo && in_range;
			MODE_EXCL: hit_lo = q_lo && !in_range;
			default:   hit_lo = 1'b0;
		endcase
	end
endmodule // pdec_completion_event_pair

// ===== hw/pdec_dcmp_pair.sv
// data address compare pair: qualifiers, exact, bit-mask or range compare
// assumes cfg is the upper 16 bits of data_compare_config
module pdec_dcmp_pair
	import pdec_pkg::*;
(
	input  wire logic [15:0] cfg,
	input  wire logic [31:0] cmp_lo,
	input  wire logic [31:0] cmp_hi,
	input  wire logic [31:0] addr,
	input  wire logic        problem_state_bit,
	input  wire logic        data_space_bit,
	output logic             hit_lo,
	output logic             hit_hi
);
	logic q_lo;
	logic q_hi;
	logic in_range;

	assign q_lo = pdec_sel_ok(cfg[PAIR_US1+:2], problem_state_bit)
		& pdec_sel_ok(cfg[PAIR_ER1+:2], data_space_bit);
	assign q_hi = pdec_sel_ok(cfg[PAIR_US2+:2], problem_state_bit)
		& pdec_sel_ok(cfg[PAIR_ER2+:2], data_space_bit);
	assign in_range = (addr >= cmp_lo) && (addr < cmp_hi);

	always_comb
	begin
		hit_lo = 1'b0;
		hit_hi = 1'b0;
		case (cfg[PAIR_MODE+:2])
			MODE_EXACT:
			begin
				hit_lo = q_lo && (addr == cmp_lo);
				hit_hi = q_hi && (addr == cmp_hi);
			end
			MODE_MASK: hit_lo = q_lo && (((addr ^ cmp_lo) & cmp_hi) == 32'h0000_0000);
			MODE_INCL: hit_lo = q_lo && in_range;
			MODE_EXCL: hit_lo = q_lo && !in_range;
			default:   hit_lo = 1'b0;
		endcase
	end
endmodule // pdec_dcmp_pair

// ===== hw/pdec_event_ctrl.sv
// debug event qualification and control: control/status registers, event gating
// by debug mode, stop state, debug interrupt, timer freeze and reset requests
// assumes pipeline event inputs are one-cycle pulses synchronous to core_clk
module pdec_event_ctrl
	import pdec_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        resetn,
	// special-register move port from the core
	input  wire logic        spr_wr,
	input  wire logic        spr_rd,
	input  wire logic [3:0]  spr_sel,
	input  wire logic [31:0] spr_wdata,
	output logic      [31:0] spr_rdata_r,
	// jtag debug port
	input  wire logic        jtag_wr,
	input  wire logic        jtag_rd,
	input  wire logic [3:0]  jtag_sel,
	input  wire logic [31:0] jtag_wdata,
	output logic      [31:0] jtag_rdata_r,
	input  wire logic        jtag_ude_req,
	input  wire logic        jtag_resume,
	input  wire logic        wait_mode_enable,
	// machine state
	input  wire logic        debug_interrupt_enable,
	input  wire logic        problem_state_bit,
	input  wire logic        instr_space_bit,
	input  wire logic        data_space_bit,
	// pipeline events
	input  wire logic        instr_complete,
	input  wire logic [31:0] instr_addr,
	input  wire logic [31:0] next_pc,
	input  wire logic        branch_taken,
	input  wire logic        irq_taken,
	input  wire logic        irq_critical,
	input  wire logic        trap_exec,
	input  wire logic        return_exec,
	input  wire logic [1:0]  return_kind,
	input  wire logic        data_access,
	input  wire logic        data_write,
	input  wire logic [31:0] data_addr,
	// results
	output logic             core_stop_r,
	output logic             debug_irq_r,
	output logic      [31:0] critical_save_pc_r,
	output logic             trace_event_r,
	output logic             timer_freeze_r,
	output logic      [1:0]  reset_request_r,
	output logic      [31:0] debug_status_r
);
	pdec_run_type run_r;
	logic [31:0]  ctrl_r;
	logic [31:0]  icfg_r;
	logic [31:0]  dcfg_r;
	logic [31:0]  iac_r [IAC_NUM];
	logic [31:0]  dac_r [DAC_NUM];
	logic         de_prev_r;

	logic        wr_en;
	logic [3:0]  wr_sel;
	logic [31:0] wr_data;
	logic        ext_act;
	logic        int_only;
	logic        de_blk;
	logic [3:0]  iac_hit;
	logic [1:0]  iac_range;
	logic [1:0]  dac_hit;
	logic [31:0] ev_raw;
	logic [31:0] ev_hit;
	logic        ude_ev;
	logic        any_ev;
	logic        stop_ev;
	logic        irq_now;
	logic        irq_late;
	logic        imprecise_ev;
	logic [1:0]  ats_flip;
	logic [31:0] stat_nxt;

	// jtag wins a same-cycle write; both ports reach every register
	assign wr_en   = spr_wr | jtag_wr;
	assign wr_sel  = jtag_wr ? jtag_sel : spr_sel;
	assign wr_data = jtag_wr ? jtag_wdata : spr_wdata;

	assign ext_act  = ctrl_r[CM_EXT] | wait_mode_enable;
	assign int_only = ctrl_r[CM_INT] & !ext_act;
	assign de_blk   = int_only & !debug_interrupt_enable;

	pdec_completion_event_pair u_iac12 (
		.cfg               (icfg_r[31:16]),
		.reversed          (debug_status_r[ST_ATS12]),
		.cmp_lo            (iac_r[0]),
		.cmp_hi            (iac_r[1]),
		.addr              (instr_addr),
		.problem_state_bit (problem_state_bit),
		.instr_space_bit   (instr_space_bit),
		.hit_lo            (iac_hit[0]),
		.hit_hi            (iac_hit[1]),
		.range_mode        (iac_range[0])
	);

	pdec_completion_event_pair u_iac34 (
		.cfg               (icfg_r[15:0]),
		.reversed          (debug_status_r[ST_ATS34]),
		.cmp_lo            (iac_r[2]),
		.cmp_hi            (iac_r[3]),
		.addr              (instr_addr),
		.problem_state_bit (problem_state_bit),
		.instr_space_bit   (instr_space_bit),
		.hit_lo            (iac_hit[2]),
		.hit_hi            (iac_hit[3]),
		.range_mode        (iac_range[1])
	);

	pdec_dcmp_pair u_dac12 (
		.cfg               (dcfg_r[31:16]),
		.cmp_lo            (dac_r[0]),
		.cmp_hi            (dac_r[1]),
		.addr              (data_addr),
		.problem_state_bit (problem_state_bit),
		.data_space_bit    (data_space_bit),
		.hit_lo            (dac_hit[0]),
		.hit_hi            (dac_hit[1])
	);

	// raw occurrences, already gated by mode; ext_act lifts every gate
	always_comb
	begin
		ev_raw = 32'h0000_0000;
		ev_raw[ST_CMP]  = instr_complete & !de_blk;
		ev_raw[ST_BRT]  = branch_taken & !de_blk;
		ev_raw[ST_INTERRUPT_EVENT] = irq_taken & !(int_only & irq_critical);
		ev_raw[ST_TRAP] = trap_exec;
		ev_raw[ST_IAC1]   = instr_complete & iac_hit[0] & !(de_blk & iac_range[0]);
		ev_raw[ST_IAC1-1] = instr_complete & iac_hit[1];
		ev_raw[ST_IAC1-2] = instr_complete & iac_hit[2] & !(de_blk & iac_range[1]);
		ev_raw[ST_IAC1-3] = instr_complete & iac_hit[3];
		ev_raw[ST_DAC1R] = data_access & !data_write & dac_hit[0];
		ev_raw[ST_DAC1W] = data_access & data_write & dac_hit[0];
		ev_raw[ST_DAC2R] = data_access & !data_write & dac_hit[1];
		ev_raw[ST_DAC2W] = data_access & data_write & dac_hit[1];
		ev_raw[ST_RET] = return_exec & !(de_blk & (return_kind != RET_RFI));
	end

	assign ev_hit  = ev_raw & ctrl_r & EV_ENABLE_MASK;
	assign ude_ev  = jtag_ude_req;
	assign any_ev  = ude_ev | (|ev_hit);
	assign stop_ev = any_ev & ext_act;
	assign irq_now = any_ev & int_only & debug_interrupt_enable;
	assign imprecise_ev = any_ev & de_blk;
	// a held-off event fires once the enable rises, if its flag survived
	assign irq_late = int_only & debug_interrupt_enable & !de_prev_r
		& debug_status_r[ST_IDE] & (|(debug_status_r & ST_EVENT_MASK));
	// toggle only on a range hit that was actually recorded
	assign ats_flip[0] = icfg_r[16 + PAIR_AT] & iac_range[0] & ev_hit[ST_IAC1];
	assign ats_flip[1] = icfg_r[PAIR_AT] & iac_range[1] & ev_hit[ST_IAC1-2];

	always_comb
	begin
		stat_nxt = debug_status_r;
		if (wr_en && wr_sel == REG_STATUS)
			stat_nxt = debug_status_r & ~wr_data;
		// setting after the clear lets a same-cycle event survive
		stat_nxt = stat_nxt | ev_hit;
		stat_nxt[ST_UDE] = stat_nxt[ST_UDE] | ude_ev;
		stat_nxt[ST_IDE] = stat_nxt[ST_IDE] | imprecise_ev;
		stat_nxt[ST_ATS12] = stat_nxt[ST_ATS12] ^ ats_flip[0];
		stat_nxt[ST_ATS34] = stat_nxt[ST_ATS34] ^ ats_flip[1];
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			debug_status_r <= ST_RESET;
		else
			debug_status_r <= stat_nxt;
	end

	// configuration registers; reserved bits are never stored and read zero
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ctrl_r <= CM_RESET;
			icfg_r <= IC_RESET;
			dcfg_r <= DC_RESET;
			for (int i = 0; i < IAC_NUM; i++)
				iac_r[i] <= 32'h0000_0000;
			for (int i = 0; i < DAC_NUM; i++)
				dac_r[i] <= 32'h0000_0000;
		end
		else if (wr_en)
		begin
			case (wr_sel)
				REG_CTRL_MAIN: ctrl_r <= wr_data & CM_WR_MASK;
				REG_INSTR_CFG: icfg_r <= wr_data & IC_WR_MASK;
				REG_DATA_CFG:  dcfg_r <= wr_data & DC_WR_MASK;
				REG_IAC_BASE, 4'h5, 4'h6, 4'h7:
					iac_r[wr_sel[1:0]] <= wr_data & IAC_WR_MASK;
				REG_DAC_BASE, 4'h9:
					dac_r[wr_sel[0]] <= wr_data;
				default: ;
			endcase
		end
	end

	// reset field is an action, not storage: one-cycle request, reads back 00
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			reset_request_r <= RST_NONE;
		else if (wr_en && wr_sel == REG_CTRL_MAIN)
			reset_request_r <= wr_data[CM_RST_H:CM_RST_L];
		else
			reset_request_r <= RST_NONE;
	end

	// stop state: left only on the tool's resume, a new stop event wins
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			run_r <= ST_RUN;
		else
		begin
			case (run_r)
				ST_RUN:  if (stop_ev) run_r <= ST_STOP;
				ST_STOP: if (jtag_resume && !stop_ev) run_r <= ST_RUN;
				default: run_r <= ST_RUN;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			core_stop_r <= 1'b0;
		else
			core_stop_r <= (run_r == ST_STOP) ? !(jtag_resume && !stop_ev) : stop_ev;
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			debug_irq_r        <= 1'b0;
			critical_save_pc_r <= 32'h0000_0000;
			de_prev_r          <= 1'b0;
		end
		else
		begin
			de_prev_r   <= debug_interrupt_enable;
			debug_irq_r <= irq_now | irq_late;
			if (irq_now || irq_late)
				critical_save_pc_r <= next_pc;
		end
	end

	// trace mode: record and report, never stop or interrupt
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			trace_event_r <= 1'b0;
		else
			trace_event_r <= any_ev & !ext_act & !ctrl_r[CM_INT];
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			timer_freeze_r <= 1'b0;
		else
			timer_freeze_r <= ctrl_r[CM_FT] & (|(debug_status_r & ST_EVENT_MASK));
	end

	function automatic logic [31:0] reg_value(input logic [3:0] sel);
		case (sel)
			REG_CTRL_MAIN: return ctrl_r;
			REG_INSTR_CFG: return icfg_r;
			REG_DATA_CFG:  return dcfg_r;
			REG_STATUS:    return debug_status_r;
			REG_IAC_BASE, 4'h5, 4'h6, 4'h7: return iac_r[sel[1:0]];
			REG_DAC_BASE, 4'h9: return dac_r[sel[0]];
			default:       return 32'h0000_0000;
		endcase
	endfunction

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			spr_rdata_r  <= 32'h0000_0000;
			jtag_rdata_r <= 32'h0000_0000;
		end
		else
		begin
			if (spr_rd)
				spr_rdata_r <= reg_value(spr_sel);
			if (jtag_rd)
				jtag_rdata_r <= reg_value(jtag_sel);
		end
	end

	sequence s_ext_ude;
		jtag_ude_req && (ctrl_r[CM_EXT] || wait_mode_enable);
	endsequence

	sequence s_stopped;
		core_stop_r && debug_status_r[ST_UDE];
	endsequence

	AST_UDE_STOP: assert property (@(posedge core_clk) disable iff (!resetn)
		s_ext_ude |=> s_stopped) else $error("ude in external mode did not stop");
	AST_UDE_NO_ENABLE: assert property (@(posedge core_clk) disable iff (!resetn)
		jtag_ude_req |=> debug_status_r[ST_UDE]) else $error("ude flag not set");
	AST_UDE_IRQ: assert property (@(posedge core_clk) disable iff (!resetn)
		(jtag_ude_req && ctrl_r[CM_INT] && !ext_act && debug_interrupt_enable)
		|=> debug_irq_r && critical_save_pc_r == $past(next_pc))
		else $error("internal ude did not interrupt");
	AST_IMPRECISE: assert property (@(posedge core_clk) disable iff (!resetn)
		(jtag_ude_req && de_blk) |=> debug_status_r[ST_IDE] && !debug_irq_r && !core_stop_r)
		else $error("held-off event mishandled");
	AST_TRACE_RUNS: assert property (@(posedge core_clk) disable iff (!resetn)
		(any_ev && !ext_act && !ctrl_r[CM_INT] && !core_stop_r)
		|=> trace_event_r && !core_stop_r && !debug_irq_r)
		else $error("trace event stopped the core");
	AST_NO_BRT_CMP: assert property (@(posedge core_clk) disable iff (!resetn)
		de_blk |=> !(|(debug_status_r[ST_CMP:ST_BRT] & ~$past(debug_status_r[ST_CMP:ST_BRT]))))
		else $error("branch or completion event while held off");
	AST_NO_CRIT_INTERRUPT_EVENT: assert property (@(posedge core_clk) disable iff (!resetn)
		(int_only && irq_critical) |-> !ev_hit[ST_INTERRUPT_EVENT])
		else $error("critical interrupt raised event");
	AST_RET_RFI_ONLY: assert property (@(posedge core_clk) disable iff (!resetn)
		(de_blk && return_kind != RET_RFI) |-> !ev_hit[ST_RET])
		else $error("critical return raised event");
	AST_RESET_REQ: assert property (@(posedge core_clk) disable iff (!resetn)
		(wr_en && wr_sel == REG_CTRL_MAIN) |=> reset_request_r == $past(wr_data[29:28])
		##1 reset_request_r == RST_NONE || $past(wr_en)) else $error("bad reset request");
	AST_FREEZE: assert property (@(posedge core_clk) disable iff (!resetn)
		(ctrl_r[CM_FT] && |(debug_status_r & ST_EVENT_MASK)) |=> timer_freeze_r)
		else $error("timers not frozen");
	AST_CLEAR_MASK: assert property (@(posedge core_clk) disable iff (!resetn)
		(wr_en && wr_sel == REG_STATUS && !any_ev && ats_flip == 2'h0 && !imprecise_ev)
		|=> debug_status_r == ($past(debug_status_r) & ~$past(wr_data)))
		else $error("status write is not a clear mask");
	AST_STOP_OVER_IRQ: assert property (@(posedge core_clk) disable iff (!resetn)
		ext_act |=> !debug_irq_r || $past(irq_late)) else $error("irq taken in external mode");
endmodule // pdec_event_ctrl

// ===== hw/pdec_pkg.sv
// shared constants for the debug event qualification and control block
// assumes the core numbers register bits msb-first; here bit 31 is the msb and the
// constants already hold the mirrored lsb-0 positions
package pdec_pkg;
	// register select codes on the special-register and jtag access ports
	localparam logic [3:0] REG_CTRL_MAIN = 4'h0;
	localparam logic [3:0] REG_INSTR_CFG = 4'h1;
	localparam logic [3:0] REG_DATA_CFG  = 4'h2;
	localparam logic [3:0] REG_STATUS    = 4'h3;
	localparam logic [3:0] REG_IAC_BASE  = 4'h4;
	localparam logic [3:0] REG_DAC_BASE  = 4'h8;
	localparam int         IAC_NUM       = 4;
	localparam int         DAC_NUM       = 2;
	// debug_control_main fields
	localparam int CM_EXT   = 31;
	localparam int CM_INT   = 30;
	localparam int CM_RST_H = 29;
	localparam int CM_RST_L = 28;
	localparam int CM_FT    = 0;
	localparam logic [31:0] CM_WR_MASK  = 32'hcfff_8001;
	localparam logic [31:0] CM_RESET    = 32'h0000_0000;
	// debug_status_reg fields; event bits share positions with their enables
	localparam int ST_IDE   = 31;
	localparam int ST_UDE   = 30;
	localparam int ST_CMP   = 27;
	localparam int ST_BRT   = 26;
	localparam int ST_INTERRUPT_EVENT  = 25;
	localparam int ST_TRAP  = 24;
	localparam int ST_IAC1  = 23;
	localparam int ST_DAC1R = 19;
	localparam int ST_DAC1W = 18;
	localparam int ST_DAC2R = 17;
	localparam int ST_DAC2W = 16;
	localparam int ST_RET   = 15;
	localparam int ST_ATS12 = 1;
	localparam int ST_ATS34 = 0;
	localparam logic [31:0] ST_EVENT_MASK = 32'h4fff_8000;
	localparam logic [31:0] EV_ENABLE_MASK = 32'h0fff_8000;
	localparam logic [31:0] ST_RESET      = 32'h0000_0000;
	// instr_compare_config: two 16-bit pair slices, pair 1/2 in the upper half
	localparam logic [31:0] IC_WR_MASK = 32'hffc1_ffc1;
	localparam logic [31:0] IC_RESET   = 32'h0000_0000;
	localparam int PAIR_US1 = 14;
	localparam int PAIR_ER1 = 12;
	localparam int PAIR_US2 = 10;
	localparam int PAIR_ER2 = 8;
	localparam int PAIR_MODE = 6;
	localparam int PAIR_AT  = 0;
	// data_compare_config: only the upper 16 bits steer this block
	localparam logic [31:0] DC_WR_MASK = 32'hffef_0f0f;
	localparam logic [31:0] DC_RESET   = 32'h0000_0000;
	localparam logic [31:0] IAC_WR_MASK = 32'hffff_fffc;
	// compare pair modes
	localparam logic [1:0] MODE_EXACT = 2'h0;
	localparam logic [1:0] MODE_MASK  = 2'h1;
	localparam logic [1:0] MODE_INCL  = 2'h2;
	localparam logic [1:0] MODE_EXCL  = 2'h3;
	// reset request codes
	localparam logic [1:0] RST_NONE = 2'h0;

	typedef enum logic [1:0] {RET_RFI = 2'h0, RET_RFCI = 2'h1, RET_RFMCI = 2'h2} pdec_ret_type;
	typedef enum logic [1:0] {ST_RUN = 2'b01, ST_STOP = 2'b10} pdec_run_type;

	// privilege/space qualifier: 00 any, 10 needs 0, 11 needs 1, 01 never
	function automatic logic pdec_sel_ok(input logic [1:0] sel, input logic bit_v);
		case (sel)
			2'h0:    return 1'b1;
			2'h2:    return !bit_v;
			2'h3:    return bit_v;
			default: return 1'b0;
		endcase
	endfunction
endpackage

// ===== testbench/pdec_jtag_tool.sv
// jtag debug tool model: register access and event requests on the jtag port
// assumes every request is launched 1 ns after a core_clk rising edge
module pdec_jtag_tool
	import pdec_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic [31:0] jtag_rdata_r,
	output logic             jtag_wr,
	output logic             jtag_rd,
	output logic      [3:0]  jtag_sel,
	output logic      [31:0] jtag_wdata,
	output logic             jtag_ude_req,
	output logic             jtag_resume
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		{jtag_wr, jtag_rd, jtag_ude_req, jtag_resume} = 4'h0;
		jtag_sel = 4'h0;
		jtag_wdata = 32'h0;
	end
	// an idle cycle ends each access so a strobe is never set twice in one step
	task automatic access(input logic w, input logic [3:0] s, input logic [31:0] d,
		output logic [31:0] q);
		jtag_sel = s;
		jtag_wdata = d;
		jtag_wr = w;
		jtag_rd = !w;
		@(posedge core_clk);
		#1;
		jtag_wr = 1'b0;
		jtag_rd = 1'b0;
		// released data does not keep its last value
		jtag_wdata = ~d;
		@(posedge core_clk);
		#1;
		q = jtag_rdata_r;
	endtask
	// returns one step after the request edge with both strobes released, so the next request may follow at once
	task automatic fire(input logic res);
		if (res)
			jtag_resume = 1'b1;
		else
			jtag_ude_req = 1'b1;
		@(posedge core_clk);
		#1;
		jtag_resume = 1'b0;
		jtag_ude_req = 1'b0;
	endtask
endmodule // pdec_jtag_tool

// ===== testbench/tb.sv
// self-checking bench for the debug event control block
// assumes the jtag tool model drives the jtag port; the bench plays the core
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pdec_pkg::*;
	logic        core_clk = 0, resetn = 0, spr_wr = 0, spr_rd = 0, wait_mode_enable = 0;
	logic        debug_interrupt_enable = 0, problem_state_bit = 0, instr_space_bit = 0;
	logic        data_space_bit = 0, instr_complete = 0, branch_taken = 0, irq_taken = 0;
	logic        irq_critical = 0, trap_exec = 0, return_exec = 0, data_access = 0;
	logic        data_write = 0;
	logic [1:0]  return_kind = 2'h0;
	logic [3:0]  spr_sel = 4'h0;
	logic [31:0] spr_wdata = 32'h0, instr_addr = 32'h0, next_pc = 32'h0, data_addr = 32'h0;
	logic [31:0] rd, spr_rdata_r, jtag_rdata_r, jtag_wdata, critical_save_pc_r, debug_status_r;
	logic [3:0]  jtag_sel;
	logic [1:0]  reset_request_r;
	logic        jtag_wr, jtag_rd, jtag_ude_req, jtag_resume, core_stop_r, debug_irq_r;
	logic        trace_event_r, timer_freeze_r;
	int          miscompares = 0, check_count = 0;
	always #12.5 core_clk = ~core_clk;
	pdec_event_ctrl dut_u (.*);
	pdec_jtag_tool tool_u (.*);
	task automatic step(int n = 1);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one idle cycle after every register change keeps old and new settings apart
	task automatic spr(logic [3:0] s, logic [31:0] d);
		spr_sel = s;
		spr_wdata = d;
		spr_wr = 1;
		step();
		spr_wr = 0;
		spr_wdata = ~d;
		step();
	endtask
	task automatic sprrd(logic [3:0] s);
		spr_sel = s;
		spr_rd = 1;
		step();
		spr_rd = 0;
		step();
		rd = spr_rdata_r;
	endtask
	task automatic pulse(ref logic s);
		s = 1;
		step();
		s = 0;
		step();
	endtask
	task automatic t_regs();
		spr(REG_CTRL_MAIN, 32'hcfff_ffff);
		tool_u.access(1'b0, REG_CTRL_MAIN, 32'h0, rd);
		chk("ctrl", CM_WR_MASK, rd);
		tool_u.access(1'b1, REG_CTRL_MAIN, 32'h0, rd);
		sprrd(REG_CTRL_MAIN);
		chk("ctrl jtag", 32'h0, rd);
		tool_u.access(1'b1, 4'hf, 32'h5a5a_5a5a, rd);
		sprrd(4'hf);
		chk("unmapped", 32'h0, rd);
		for (int c = 1; c < 4; c++)
		begin
			spr_sel = REG_CTRL_MAIN;
			spr_wdata = {2'h0, c[1:0], 28'h0};
			spr_wr = 1;
			step();
			spr_wr = 0;
			chk("reset req", c, reset_request_r);
			step();
			chk("reset idle", 32'h0, reset_request_r);
		end
	endtask
	task automatic t_ext();
		debug_interrupt_enable = 1;
		next_pc = 32'h0000_0120;
		spr(REG_CTRL_MAIN, 32'hc000_0000);
		tool_u.fire(1'b0);
		chk("stop", 32'h1, core_stop_r);
		chk("no irq", 32'h0, debug_irq_r);
		step();
		spr(REG_STATUS, 32'h0);
		chk("status", 32'h1 << ST_UDE, debug_status_r);
		tool_u.fire(1'b1);
		chk("resumed", 32'h0, core_stop_r);
		spr(REG_STATUS, 32'hffff_ffff);
		chk("cleared", 32'h0, debug_status_r);
	endtask
	task automatic t_int();
		debug_interrupt_enable = 0;
		// completion and branch events enabled here together with internal mode
		spr(REG_CTRL_MAIN, 32'h4c00_0001);
		pulse(branch_taken);
		pulse(instr_complete);
		chk("gated", 32'h0, debug_status_r);
		next_pc = 32'h0000_0240;
		tool_u.fire(1'b0);
		chk("imprecise", (32'h1 << ST_UDE) | (32'h1 << ST_IDE), debug_status_r);
		chk("held irq", 32'h0, debug_irq_r);
		step();
		chk("freeze", 32'h1, timer_freeze_r);
		debug_interrupt_enable = 1;
		next_pc = 32'h0000_0300;
		step();
		chk("late irq", 32'h1, debug_irq_r);
		chk("late pc", 32'h0000_0300, critical_save_pc_r);
		spr(REG_STATUS, 32'hffff_ffff);
		chk("thaw", 32'h0, timer_freeze_r);
		next_pc = 32'h0000_0440;
		tool_u.fire(1'b0);
		chk("irq", 32'h1, debug_irq_r);
		chk("save pc", 32'h0000_0440, critical_save_pc_r);
		step();
	endtask
	task automatic t_trace();
		spr(REG_CTRL_MAIN, 32'h0);
		tool_u.fire(1'b0);
		chk("trace", 32'h1, trace_event_r);
		chk("runs", 32'h0, core_stop_r);
		step();
	endtask
	// compare engines and mode gating, then wait mode
	task automatic t_cmp();
		logic [31:0] e;
		debug_interrupt_enable = 0;
		spr(REG_IAC_BASE, 32'h0000_0100);
		spr(4'h5, 32'h0000_0200);
		spr(4'h6, 32'h0000_0300);
		spr(REG_DAC_BASE, 32'h1234_5600);
		spr(4'h9, 32'hffff_ff00);
		// pair 1/2 inclusive with auto-toggle; iac3 user only and needs space bit 0
		spr(REG_INSTR_CFG, 32'h0081_e000);
		// dac pair in bit-mask mode; dac1 needs data space bit 0
		spr(REG_DATA_CFG, 32'h2040_0000);
		// internal only: interrupt_event, iac1-4, dac1 read/write and ret enabled
		spr(REG_CTRL_MAIN, 32'h42fc_8000);
		spr(REG_STATUS, 32'hffff_ffff);
		instr_addr = 32'h0000_0180;
		pulse(instr_complete);
		irq_critical = 1;
		pulse(irq_taken);
		return_kind = 2'h1;
		pulse(return_exec);
		instr_addr = 32'h0000_0300;
		problem_state_bit = 1;
		instr_space_bit = 1;
		pulse(instr_complete);
		chk("held off", 32'h0, debug_status_r);
		problem_state_bit = 0;
		instr_space_bit = 0;
		pulse(instr_complete);
		chk("iac user", 32'h0, debug_status_r);
		problem_state_bit = 1;
		return_kind = 2'h0;
		pulse(return_exec);
		pulse(instr_complete);
		e = (32'h1 << ST_IDE) | (32'h1 << ST_RET) | (32'h1 << (ST_IAC1 - 2));
		chk("iac exact", e, debug_status_r);
		spr(REG_STATUS, 32'hffff_ffff);
		data_addr = 32'h1234_56ab;
		data_space_bit = 1;
		pulse(data_access);
		chk("dac space", 32'h0, debug_status_r);
		data_space_bit = 0;
		pulse(data_access);
		data_write = 1;
		data_addr = 32'h1334_56ab;
		pulse(data_access);
		e = (32'h1 << ST_IDE) | (32'h1 << ST_DAC1R);
		chk("dac mask", e, debug_status_r);
		spr(REG_STATUS, 32'hffff_ffff);
		debug_interrupt_enable = 1;
		instr_addr = 32'h0000_0180;
		pulse(instr_complete);
		e = (32'h1 << ST_IAC1) | (32'h1 << ST_ATS12);
		chk("iac range", e, debug_status_r);
		spr(REG_STATUS, 32'h1 << ST_IAC1);
		pulse(instr_complete);
		chk("iac toggled", 32'h1 << ST_ATS12, debug_status_r);
		debug_interrupt_enable = 0;
		wait_mode_enable = 1;
		tool_u.fire(1'b0);
		chk("wait stop", 32'h1, core_stop_r);
		tool_u.fire(1'b1);
		wait_mode_enable = 0;
		chk("wait resume", 32'h0, core_stop_r);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		#100us;
		miscompares++;
		final_report();
	end
	initial
	begin
		step(12);
		resetn = 1;
		step();
		t_regs();
		t_ext();
		t_int();
		t_trace();
		t_cmp();
		final_report();
	end
endmodule // tb
